// File: core/rcf_regs.svh
// Offsets, widths, lengths, reset values and timing counts of the
// receive control block. Definitions only; included by bare name.
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

// Register byte offsets on the 32-bit Wishbone bus.
`define RCF_OFF_CTRL   8'h74
`define RCF_OFF_MAC_LO 8'h80
`define RCF_OFF_MAC_HI 8'h84
`define RCF_OFF_HASH   8'h88
`define RCF_OFF_STATUS 8'h8c
`define RCF_OFF_DATA   8'h90

// Control register width and reset value (physical filter set).
`define RCF_CTRL_W     16
`define RCF_CTRL_RST   16'h0800

// Destination address length in bytes.
`define RCF_DA_BYTES   4'h6

// A pause quantum is 512 bit times; one bit is 10 ns at 100 Mb/s.
`define RCF_QUANTUM_BITS 512
`define RCF_BIT_NS       10
`define RCF_CLK_NS       10
`define RCF_QUANTUM_CYC  (`RCF_QUANTUM_BITS * `RCF_BIT_NS / `RCF_CLK_NS)

`endif

// File: core/rcf_pkg.sv
// Types shared by the receive control block and its helpers.
// Assumes rcf_regs.svh for numeric constants.
package rcf_pkg;

  // Control register, bit 15 first.
  typedef struct packed {
    logic       flush;
    logic       udp_chk;
    logic       tcp_chk;
    logic       ip_chk;
    logic       phys_filt;
    logic       pause_en;
    logic       crc_keep;
    logic       mcast_filt;
    logic       bcast_acc;
    logic       all_mcast;
    logic       ucast_acc;
    logic       promisc;
    logic [1:0] spare;
    logic       inverse;
    logic       rx_en;
  } rcf_ctrl_t;

  // One received byte with its frame markers and end-of-frame status.
  typedef struct packed {
    logic        valid;
    logic        first;
    logic        last;
    logic [7:0]  data;
    logic        crc_err;
    logic        is_ip;
    logic        ip_bad;
    logic        is_tcp;
    logic        tcp_bad;
    logic        is_udp;
    logic        udp_bad;
    logic        is_pause;
    logic [15:0] quanta;
  } rcf_rx_t;

  typedef enum logic [1:0] {
    RCF_STOP,
    RCF_IDLE,
    RCF_RECV,
    RCF_SKIP
  } rcf_state_t;

endpackage

// File: core/rcf_queue_mem.sv
// Receive queue byte memory with one write and one registered read port.
// Assumes a single clock; contents are undefined until written.
`timescale 1ns/1ps
module rcf_queue_mem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // Clock.
  input  wire logic          clk_sys,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read first, so a same-address read returns the old byte; read registered so the read port maps to block RAM.
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// File: core/rcf_addr_filter.sv
// Destination address decision of the receive control block.
// Assumes da holds the first six frame bytes, first byte at the top.
`timescale 1ns/1ps
module rcf_addr_filter (
  // Control.
  input  wire rcf_pkg::rcf_ctrl_t ctrl,
  // Addresses.
  input  wire logic [47:0]        da,
  input  wire logic [47:0]        mac,
  input  wire logic [31:0]        hash,
  // Decision.
  output logic                    accept
);

  logic is_mc;
  logic is_bc;
  logic own;
  logic hit;

  // Group bit is the low bit of the first address byte.
  assign is_mc = da[40];
  assign is_bc = &da;
  assign own   = (da == mac);
  assign hit   = hash[da[4:0]];

  // Any enabled category matching passes; inverse flips the match.
  always_comb begin
    logic m;
    m = 1'b0;
    m = m | (is_bc & ctrl.bcast_acc);
    m = m | (is_mc & ctrl.all_mcast);
    m = m | (!is_mc & own & ctrl.ucast_acc);
    m = m | (!is_mc & own & ctrl.phys_filt);
    m = m | (is_mc & !is_bc & hit & ctrl.mcast_filt);
    accept = ctrl.promisc | (ctrl.inverse ? !m : m);
  end

endmodule

// File: core/rcf_rx_ctrl.sv
// Receive control and address/checksum filtering for a single-port MAC.
// Assumes a 100 MHz clk_sys, a byte-wide link already in that domain,
// and a classic Wishbone master on a 32-bit bus.
`timescale 1ns/1ps
`include "rcf_regs.svh"
module rcf_rx_ctrl #(
  parameter int AW = 10
) (
  // Clock and reset.
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // Wishbone slave.
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic                 wb_ack_o,
  output logic      [31:0]     wb_dat_o,
  // Link side.
  input  wire rcf_pkg::rcf_rx_t rx,
  input  wire logic            full_duplex,
  // Status toward the MAC.
  output logic                 tx_hold,
  output logic                 rx_running
);

  // Pointers carry one bit more than the memory address, so a full queue
  // and an empty one differ without a separate flag.
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

  // All state but the reset pipe and the queue memory lives in one packed
  // word: the comb process builds the next copy and a single flop bank registers it.
  typedef struct packed {
    rcf_pkg::rcf_ctrl_t  ctrl;
    logic [47:0]         mac;
    logic [31:0]         hash;
    rcf_pkg::rcf_state_t st;
    logic [AW:0]         wr;
    logic [AW:0]         base;
    logic [AW:0]         rd;
    logic [AW-1:0]       clr;
    logic [3:0]          dcnt;
    logic                ovf;
    logic [47:0]         da;
    logic [7:0]          frames;
    logic [31:0]         timer;
    logic                hold;
    logic                ack;
    logic [31:0]         rdata;
  } rcf_core_t;

  rcf_core_t     s;
  rcf_core_t     n;
  logic [1:0]    rst_pipe;
  logic          rst_sync_n;
  logic          mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0]    mem_wdata;
  logic [7:0]    mem_q;
  logic          addr_ok;

  // Merge write data into a 32-bit register under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Release reset through two flops so no flop leaves reset mid-edge.
  // A reset pulse shorter than two edges still clears the core at once.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // Queue storage; it reads at the next pointer, so the byte under the
  // read pointer already stands registered when a pop is taken.
  rcf_queue_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .clk_sys (clk_sys),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (n.rd[AW-1:0]),
    .rdata   (mem_q)
  );

  // Address decision on the captured destination; it is settled by the
  // last byte of any frame of seven bytes or more.
  rcf_addr_filter u_filt (
    .ctrl   (s.ctrl),
    .da     (s.da),
    .mac    (s.mac),
    .hash   (s.hash),
    .accept (addr_ok)
  );

  // Next state: bus access, then the link side, then the pause timer.
  // Every local gets a value at the top, so no path can leave a latch.
  always_comb begin
    logic        req;
    logic [31:0] c32;
    logic [AW:0] fw;
    logic [AW:0] avail;
    logic        take;
    logic        room;
    logic        ovf_now;
    logic        keep;
    logic        csum_bad;
    req      = wb_cyc_i & wb_stb_i & !s.ack;
    c32      = 32'h0;
    fw       = s.wr;
    avail    = s.base - s.rd;
    take     = 1'b0;
    room     = 1'b0;
    ovf_now  = 1'b0;
    keep     = 1'b0;
    csum_bad = 1'b0;
    n         = s;
    n.ack     = 1'b0;
    mem_we    = 1'b0;
    mem_waddr = s.wr[AW-1:0];
    mem_wdata = rx.data;

    // One access per request; ack comes one cycle after the request.
    if (req) begin
      n.ack   = 1'b1;
      n.rdata = 32'h0;
      case (wb_adr_i)
        `RCF_OFF_CTRL: begin
          c32 = {16'h0, s.ctrl};
          if (wb_we_i) begin
            c32    = merge(c32, wb_dat_i, wb_sel_i);
            n.ctrl = c32[`RCF_CTRL_W-1:0];
          end else begin
            n.rdata = c32;
          end
        end
        `RCF_OFF_MAC_LO: begin
          if (wb_we_i) begin
            n.mac[31:0] = merge(s.mac[31:0], wb_dat_i, wb_sel_i);
          end else begin
            n.rdata = s.mac[31:0];
          end
        end
        `RCF_OFF_MAC_HI: begin
          // The upper half holds the first two address bytes on the wire.
          c32 = {16'h0, s.mac[47:32]};
          if (wb_we_i) begin
            c32          = merge(c32, wb_dat_i, wb_sel_i);
            n.mac[47:32] = c32[15:0];
          end else begin
            n.rdata = c32;
          end
        end
        `RCF_OFF_HASH: begin
          if (wb_we_i) begin
            n.hash = merge(s.hash, wb_dat_i, wb_sel_i);
          end else begin
            n.rdata = s.hash;
          end
        end
        `RCF_OFF_STATUS: begin
          // A snapshot only; the frame count wraps and only flush or reset clears it.
          if (!wb_we_i) begin
            n.rdata = {16'(avail), s.frames, 4'h0,
                       s.ctrl.flush, s.hold,
                       (s.st == rcf_pkg::RCF_RECV),
                       (s.st != rcf_pkg::RCF_STOP)};
          end
        end
        `RCF_OFF_DATA: begin
          // A read pops one committed byte; bit 8 says it was valid.
          // Reading while empty or flushing answers zero and moves nothing.
          if (!wb_we_i && avail != '0 && !s.ctrl.flush) begin
            n.rdata = {23'h0, 1'b1, mem_q};
            n.rd    = s.rd + (AW+1)'(1);
          end
        end
        default: begin
          // Unmapped offsets still answer, so a stray access cannot hang.
          n.rdata = 32'h0;
        end
      endcase
    end

    if (s.ctrl.flush) begin
      // Empty the queue and sweep zeros through it while held.
      // The sweep takes one address per cycle; clearing flush early leaves
      // stale bytes behind, harmless as the pointers are back at zero.
      n.wr      = '0;
      n.base    = '0;
      n.rd      = '0;
      n.frames  = 8'h0;
      n.clr     = s.clr + AW'(1);
      mem_we    = 1'b1;
      mem_waddr = s.clr;
      mem_wdata = 8'h0;
      if (s.st == rcf_pkg::RCF_RECV) begin
        n.st = rcf_pkg::RCF_SKIP;
      end
    end else begin
      n.clr = '0;
      case (s.st)
        rcf_pkg::RCF_STOP: begin
          if (s.ctrl.rx_en) begin
            n.st = rcf_pkg::RCF_IDLE;
          end
        end
        rcf_pkg::RCF_IDLE: begin
          if (!s.ctrl.rx_en) begin
            n.st = rcf_pkg::RCF_STOP;
          end else if (rx.valid && rx.first) begin
            take = 1'b1;
          end else if (rx.valid && !rx.last) begin
            // Joined in mid-frame: skip to its end so no headless frame
            // ever reaches the queue.
            n.st = rcf_pkg::RCF_SKIP;
          end
        end
        rcf_pkg::RCF_RECV: begin
          // The frame runs to its end even if enable drops.
          take = rx.valid;
        end
        rcf_pkg::RCF_SKIP: begin
          if (rx.valid && rx.last) begin
            n.st = s.ctrl.rx_en ? rcf_pkg::RCF_IDLE : rcf_pkg::RCF_STOP;
          end
        end
        default: begin
          n.st = rcf_pkg::RCF_STOP;
        end
      endcase
    end

    if (take) begin
      // A new frame starts at the committed end of the queue.
      fw = rx.first ? s.base : s.wr;
      // Overflow sticks for the rest of the frame, so a frame that lost a
      // byte is never committed half stored.
      ovf_now = rx.first ? 1'b0 : s.ovf;
      room = (fw - s.rd) < DEPTH;
      if (room && !ovf_now) begin
        mem_we    = 1'b1;
        mem_waddr = fw[AW-1:0];
        mem_wdata = rx.data;
        n.wr      = fw + (AW+1)'(1);
      end else begin
        ovf_now = 1'b1;
        n.wr    = fw;
      end
      n.ovf  = ovf_now;
      n.dcnt = rx.first ? 4'h1 : s.dcnt;
      if (rx.first || s.dcnt < `RCF_DA_BYTES) begin
        n.da = {s.da[39:0], rx.data};
        if (!rx.first) begin
          n.dcnt = s.dcnt + 4'h1;
        end
      end
      n.st = rcf_pkg::RCF_RECV;
      if (rx.last) begin
        // Each checksum only counts for frames of its own protocol.
        csum_bad = (s.ctrl.udp_chk & rx.is_udp & rx.udp_bad)
                 | (s.ctrl.tcp_chk & rx.is_tcp & rx.tcp_bad)
                 | (s.ctrl.ip_chk & rx.is_ip & rx.ip_bad);
        // Pause frames are used up here and never reach the host.
        keep = addr_ok & !ovf_now & !csum_bad & !rx.is_pause
             & (!rx.crc_err | s.ctrl.crc_keep);
        if (keep) begin
          n.base   = n.wr;
          n.frames = s.frames + 8'h1;
        end else begin
          n.wr = s.base;
        end
        n.st = s.ctrl.rx_en ? rcf_pkg::RCF_IDLE
                            : rcf_pkg::RCF_STOP;
      end
    end

    // Pause timer counts quanta of 512 bit times; a new frame reloads.
    // Thirty-two bits hold the largest quanta value times one quantum.
    if (s.timer != 32'h0) begin
      n.timer = s.timer - 32'h1;
    end
    if (take && rx.last && rx.is_pause && !rx.crc_err
        && full_duplex && s.ctrl.pause_en) begin
      n.timer = 32'(rx.quanta) * 32'(`RCF_QUANTUM_CYC);
    end
    n.hold = (n.timer != 32'h0);
  end

  // Register all state; reset takes constants only.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s        <= '0;
      s.ctrl   <= rcf_pkg::rcf_ctrl_t'(`RCF_CTRL_RST);
      s.st     <= rcf_pkg::RCF_STOP;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state flops.
  // The running flag is a compare on state flops, with no bus path.
  assign wb_ack_o   = s.ack;
  assign wb_dat_o   = s.rdata;
  assign tx_hold    = s.hold;
  assign rx_running = (s.st != rcf_pkg::RCF_STOP);

endmodule

// File: testbench/rcf_link_model.sv
// Link partner that streams received frames into the block.
// Assumes one caller at a time and frames sent whole, first to last.
`timescale 1ns/1ps
module rcf_link_model (
  // Clock.
  input  wire logic        clk_sys,
  // Byte stream toward the block.
  output rcf_pkg::rcf_rx_t rx
);
  logic busy = 1'h0;

  initial rx = '0;

  // Idle data keeps toggling so a stale byte never passes for a real one.
  always @(posedge clk_sys) begin
    if (!busy) begin
      rx.valid <= 1'h0;
      rx.data  <= ~rx.data;
    end
  end

  // Sends one frame; end-of-frame status rides only on the last byte.
  task automatic send(input logic [47:0] da, input int len,
                      input logic [6:0] fl, input logic [15:0] qu,
                      input logic pz);
    rcf_pkg::rcf_rx_t nx;
    busy = 1'h1;
    for (int i = 0; i < len; i++) begin
      @(posedge clk_sys);
      nx       = '0;
      nx.valid = 1'h1;
      nx.first = (i == 0);
      nx.last  = (i == len - 1);
      nx.data  = (i < 6) ? da[47 - 8 * i -: 8] : 8'(i);
      if (nx.last) begin
        {nx.crc_err, nx.is_ip, nx.ip_bad, nx.is_tcp, nx.tcp_bad,
         nx.is_udp, nx.udp_bad} = fl;
        nx.is_pause = pz;
        nx.quanta   = qu;
      end
      rx <= nx;
    end
    @(posedge clk_sys);
    rx.valid <= 1'h0;
    busy = 1'h0;
  endtask
endmodule

// File: testbench/rcf_rx_ctrl_properties.sv
// Port checks on the receive control block, bound to its top.
// Assumes a shadow of the control word kept from acknowledged writes.
`timescale 1ns/1ps
`include "rcf_regs.svh"
module rcf_rx_ctrl_properties (
  // Clock and reset.
  input wire logic             clk_sys,
  input wire logic             rst_n,
  // Wishbone slave.
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic             wb_ack_o,
  input wire logic [31:0]      wb_dat_o,
  // Link and status.
  input wire rcf_pkg::rcf_rx_t rx,
  input wire logic             full_duplex,
  input wire logic             tx_hold,
  input wire logic             rx_running
);
  logic [15:0] sh;
  logic        inf;
  logic        wr_c;
  logic        rd_st;
  logic        rd_dt;

  // Decodes qualified by the acknowledge that completes the transfer.
  assign wr_c  = wb_ack_o && wb_we_i && wb_adr_i == `RCF_OFF_CTRL;
  assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == `RCF_OFF_STATUS;
  assign rd_dt = wb_ack_o && !wb_we_i && wb_adr_i == `RCF_OFF_DATA;

  // A frame opens only while running, so the flag follows rx_running.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh  <= `RCF_CTRL_RST;
      inf <= 1'h0;
    end else begin
      if (wr_c && wb_sel_i[0]) sh[7:0] <= wb_dat_i[7:0];
      if (wr_c && wb_sel_i[1]) sh[15:8] <= wb_dat_i[15:8];
      if (rx.valid && rx.last) inf <= 1'h0;
      else if (rx.valid && rx.first && rx_running) inf <= 1'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_enable_runs: assert property (
    wr_c && wb_sel_i[0] && wb_dat_i[0]
    && !(wb_sel_i[1] ? wb_dat_i[15] : sh[15])
    |-> ##[1:3] rx_running) else $error("receiver did not start");
  a_no_mid_stop: assert property (
    inf && !sh[15] |-> !$fell(rx_running)) else $error("stop inside frame");
  a_idle_stop: assert property (
    wr_c && wb_sel_i[0] && !wb_dat_i[0] && !inf && !rx.valid
    |-> ##[1:3] (!rx_running || inf)) else $error("receiver kept running");
  a_flush_status: assert property (
    rd_st && sh[15] && $past(sh[15], 2) |-> wb_dat_o[31:8] == 24'h0)
    else $error("status not cleared by flush");
  a_flush_data: assert property (
    rd_dt && sh[15] && $past(sh[15], 2) |-> wb_dat_o == 32'h0)
    else $error("data returned during flush");
  a_pause_off: assert property (
    (!sh[10] || !full_duplex) && !tx_hold |=> !tx_hold)
    else $error("transmit held without pause honour");
  a_hold_min: assert property (
    $rose(tx_hold) |=> tx_hold [*8]) else $error("transmit hold too short");
  a_pause_rise: assert property (
    inf && rx.valid && rx.last && rx.is_pause && rx.quanta != 16'h0 &&
    !rx.crc_err && sh[10] && sh[4] && full_duplex && !sh[15] |=> tx_hold)
    else $error("pause frame did not hold transmit");
endmodule

bind rcf_rx_ctrl rcf_rx_ctrl_properties rcf_rx_ctrl_properties_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .rx(rx), .full_duplex(full_duplex),
  .tx_hold(tx_hold), .rx_running(rx_running));

// File: testbench/tb_mac_receive_control_filter.sv
// Self-checking bench: a table of filter cases, then stop, flush, pause
// and reset cases. Assumes the link model and the bound checker.
`timescale 1ns/1ps
`include "rcf_regs.svh"
`define CHK(nm, e, a) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) begin \
      n_errors++; \
      $display("mismatch %s exp %h got %h", nm, e, a); \
    end \
  end
module tb_mac_receive_control_filter;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [47:0] da;
    logic [6:0]  fl;
    logic        acc;
  } rcf_row_t;
  localparam logic [47:0] st = 48'h0211_2233_4455;
  localparam logic [47:0] ot = 48'h0211_2233_4466;
  localparam logic [47:0] bc = 48'hffff_ffff_ffff;
  localparam logic [47:0] mc = 48'h0100_5e00_0001;
  localparam logic [47:0] mm = 48'h0100_5e00_0002;
  // Control word, destination, end status and whether it is kept.
  localparam rcf_row_t rows [18] = '{
    '{16'h0801, st, 7'h00, 1'h1},
    '{16'h0801, ot, 7'h00, 1'h0},
    '{16'h0001, st, 7'h00, 1'h0},
    '{16'h0021, st, 7'h00, 1'h1},
    '{16'h0081, bc, 7'h00, 1'h1},
    '{16'h0041, mc, 7'h00, 1'h1},
    '{16'h0041, bc, 7'h00, 1'h1},
    '{16'h0101, mc, 7'h00, 1'h1},
    '{16'h0101, mm, 7'h00, 1'h0},
    '{16'h0011, ot, 7'h00, 1'h1},
    '{16'h0803, st, 7'h00, 1'h0},
    '{16'h0803, ot, 7'h00, 1'h1},
    '{16'h0801, st, 7'h40, 1'h0},
    '{16'h0a01, st, 7'h40, 1'h1},
    '{16'h4801, st, 7'h03, 1'h0},
    '{16'h2801, st, 7'h0c, 1'h0},
    '{16'h1801, st, 7'h30, 1'h0},
    '{16'h7801, st, 7'h15, 1'h1}
  };
  logic             clk_sys;
  logic             rst_n;
  logic             wb_cyc_i;
  logic             wb_stb_i;
  logic             wb_we_i;
  logic [7:0]       wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i;
  logic             wb_ack_o;
  logic [31:0]      wb_dat_o;
  rcf_pkg::rcf_rx_t rx;
  logic             full_duplex;
  logic             tx_hold;
  logic             rx_running;
  logic [31:0]      q;
  logic [7:0]       exp_cnt;
  int               n;
  int               n_errors;
  int               samples_checked;

  rcf_rx_ctrl #(.AW(10)) rcf_rx_ctrl_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .rx(rx), .full_duplex(full_duplex),
    .tx_hold(tx_hold), .rx_running(rx_running));
  rcf_link_model rcf_link_model_inst (.clk_sys(clk_sys), .rx(rx));

  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One classic cycle; held until ack is sampled, read data lands in q.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 64);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // Frame into the block, then the accepted count read back.
  task automatic frame(input logic [47:0] da, input logic [6:0] fl);
    rcf_link_model_inst.send(da, 16, fl, 16'h0, 1'h0);
    repeat (3) @(posedge clk_sys);
    wb(1'h0, `RCF_OFF_STATUS, 32'h0);
  endtask

  initial begin
    rst_n = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    full_duplex = 1'h0;
    n_errors = 0;
    samples_checked = 0;
    exp_cnt = 8'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    wb(1'h1, `RCF_OFF_MAC_LO, 32'h2233_4455);
    wb(1'h1, `RCF_OFF_MAC_HI, 32'h0000_0211);
    // Only hash bit 1 is set: mc lands on it, mm does not.
    wb(1'h1, `RCF_OFF_HASH, 32'h0000_0002);
    wb(1'h1, `RCF_OFF_CTRL, 32'hffff_0801);
    wb(1'h0, `RCF_OFF_CTRL, 32'h0);
    `CHK("ctrl_rd", 32'h0000_0801, q)
    wb(1'h0, 8'hfc, 32'h0);
    `CHK("unmapped", 32'h0, q)
    foreach (rows[i]) begin
      wb(1'h1, `RCF_OFF_CTRL, {16'h0, rows[i].ctrl});
      exp_cnt = exp_cnt + {7'h0, rows[i].acc};
      frame(rows[i].da, rows[i].fl);
      `CHK("count", exp_cnt, q[15:8])
    end
    // The oldest stored byte comes out first, one byte per read.
    wb(1'h0, `RCF_OFF_DATA, 32'h0);
    `CHK("pop_first", 32'h0000_0102, q)
    wb(1'h0, `RCF_OFF_DATA, 32'h0);
    `CHK("pop_next", 32'h0000_0111, q)
    // Enable cleared mid-frame: that frame still completes and counts.
    wb(1'h1, `RCF_OFF_CTRL, 32'h0801);
    fork
      rcf_link_model_inst.send(st, 40, 7'h0, 16'h0, 1'h0);
      begin
        repeat (4) @(posedge clk_sys);
        wb(1'h1, `RCF_OFF_CTRL, 32'h0800);
        `CHK("run_mid", 1'h1, rx_running)
      end
    join
    exp_cnt = exp_cnt + 8'h1;
    repeat (3) @(posedge clk_sys);
    `CHK("run_end", 1'h0, rx_running)
    frame(st, 7'h0);
    `CHK("count_stop", exp_cnt, q[15:8])
    // Flush with a non-empty queue, in the host's documented order.
    wb(1'h1, `RCF_OFF_CTRL, 32'h8800);
    wb(1'h0, `RCF_OFF_STATUS, 32'h0);
    `CHK("flush_st", 24'h0, q[31:8])
    wb(1'h0, `RCF_OFF_DATA, 32'h0);
    `CHK("flush_dat", 32'h0, q)
    wb(1'h1, `RCF_OFF_CTRL, 32'h0800);
    wb(1'h1, `RCF_OFF_CTRL, 32'h0c11);
    full_duplex <= 1'h1;
    repeat (3) @(posedge clk_sys);
    `CHK("run_on", 1'h1, rx_running)
    // One pause quantum in full duplex; the pause frame is not stored.
    rcf_link_model_inst.send(st, 20, 7'h0, 16'h1, 1'h1);
    n = 0;
    while (tx_hold !== 1'h1 && n < 8) begin
      @(posedge clk_sys);
      n++;
    end
    if (tx_hold !== 1'h1) begin
      n_errors++;
      give_verdict();
    end
    n = 0;
    while (tx_hold === 1'h1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (tx_hold === 1'h1) begin
      n_errors++;
      give_verdict();
    end
    `CHK("hold_len", 1'h1, n >= 511 && n <= 512)
    wb(1'h0, `RCF_OFF_STATUS, 32'h0);
    `CHK("pause_cnt", 8'h0, q[15:8])
    full_duplex <= 1'h0;
    rcf_link_model_inst.send(st, 20, 7'h0, 16'h1, 1'h1);
    repeat (3) @(posedge clk_sys);
    `CHK("hold_half", 1'h0, tx_hold)
    full_duplex <= 1'h1;
    wb(1'h1, `RCF_OFF_CTRL, 32'h0811);
    rcf_link_model_inst.send(st, 20, 7'h0, 16'h1, 1'h1);
    repeat (3) @(posedge clk_sys);
    `CHK("hold_off", 1'h0, tx_hold)
    // Reset in mid-run restores the control word default.
    rst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    `CHK("run_rst", 1'h0, rx_running)
    rst_n <= 1'h1;
    repeat (5) @(posedge clk_sys);
    wb(1'h0, `RCF_OFF_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'h0000_0800, q)
    // One byte lane only: the upper byte, flush included, must stay put.
    wb_sel_i <= 4'h1;
    wb(1'h1, `RCF_OFF_CTRL, 32'hffff_ff11);
    wb(1'h0, `RCF_OFF_CTRL, 32'h0);
    `CHK("ctrl_lane", 32'h0000_0811, q)
    `CHK("run_lane", 1'h1, rx_running)
    give_verdict();
  end
endmodule
